// >>> design/fbrw_ctrl.sv
// synchronous burst read, data hold and wait pin control
`timescale 1ns/1ps
`include "fbrw_map.svh"
module fbrw_ctrl
	import fbrw_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire fbrw_pins_t pins,
	input wire logic [`FBRW_ADDR_W-1:0] addr_pin,
	input wire logic nonarray_sel,
	input wire logic [15:0] nonarray_data,
	input wire logic [15:0] array_rdata,
	output logic [`FBRW_ADDR_W-1:0] array_addr,
	output logic [15:0] dq_o,
	output logic dq_oe,
	output logic wait_o,
	output logic wait_oe,
	input wire fbrw_reg_req_t reg_req,
	output logic [15:0] reg_rdata
);
	typedef struct packed {
		fbrw_state_t st;
		logic [15:0] cfg;
		logic [`FBRW_ADDR_W-1:0] addr;
		logic [`FBRW_ADDR_W-1:0] start;
		logic [2:0] cnt;
		logic hold;
		logic [4:0] words;
		logic row_done;
		logic nonarray;
		logic wait_act;
		logic wait_lvl;
		logic wait_oe;
		logic [15:0] dq;
		logic dq_oe;
		logic [15:0] rdata;
	} fbrw_regs_t;

	fbrw_regs_t r;
	fbrw_regs_t r_nxt;

	logic valid_edge;
	logic [`FBRW_ADDR_W-1:0] step_addr;
	logic at_top;
	logic sync_mode;
	logic hold2;
	logic nowrap;
	logic [2:0] lat_code;
	logic [2:0] blen;
	logic fixed_len;
	logic [2:0] ws;
	logic [2:0] lead;
	logic bus_on;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [4:0] burst_words(input logic [2:0] code);
		unique case (code)
			`FBRW_BLEN_4: burst_words = `FBRW_LEN_4;
			`FBRW_BLEN_8: burst_words = `FBRW_LEN_8;
			`FBRW_BLEN_16: burst_words = `FBRW_LEN_16;
			default: burst_words = '0;
		endcase
	endfunction

	// row-crossing wait states from latency and start offset in its group
	function automatic logic [2:0] row_waits(input logic [2:0] lat,
			input logic [`FBRW_GRP_W-1:0] off);
		logic [3:0] sum;
		sum = {1'b0, lat} + {2'b00, off};
		if (off == '0) begin
			row_waits = '0;
		end else if (sum > {1'b0, `FBRW_GRP_FULL}) begin
			row_waits = 3'(sum - {1'b0, `FBRW_GRP_FULL});
		end else begin
			row_waits = '0;
		end
	endfunction

	// ****************************************************************
	// sub blocks
	// ****************************************************************
	fbrw_edge u_edge (
		.clk(clk),
		.resetn(resetn),
		.clk_pin(pins.clk_pin),
		.rise_sel(r.cfg[`FBRW_CE]),
		.valid_edge(valid_edge)
	);

	fbrw_addr_step u_step (
		.cur(r.addr),
		.wrap_en(~nowrap & fixed_len),
		.len_code(blen),
		.nxt(step_addr),
		.at_top(at_top)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		sync_mode = ~r.cfg[`FBRW_READ_MODE];
		hold2 = r.cfg[`FBRW_HOLD2];
		nowrap = r.cfg[`FBRW_WRAP_OFF];
		lat_code = r.cfg[`FBRW_LAT_HI:`FBRW_LAT_LO];
		blen = r.cfg[`FBRW_BLEN_HI:`FBRW_BLEN_LO];
		fixed_len = (burst_words(blen) != '0);
		ws = row_waits(lat_code, r.start[`FBRW_GRP_W-1:0]);
		// edges before data at which wait already drops
		lead = r.cfg[`FBRW_WAIT_EARLY] ? (hold2 ? 3'h2 : 3'h1) : 3'h0;
		bus_on = ~pins.ce_n & ~pins.oe_n;
		r_nxt = r;

		if (reg_req.wr && reg_req.addr == `FBRW_OFF_CFG) begin
			r_nxt.cfg = reg_req.wdata & `FBRW_CFG_WMASK;
		end
		r_nxt.rdata = '0;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`FBRW_OFF_CFG: r_nxt.rdata = r.cfg;
				`FBRW_OFF_STAT: r_nxt.rdata = {5'h00, r.st, r.row_done, r.wait_act,
					r.nonarray, r.words};
				default: r_nxt.rdata = '0;
			endcase
		end

		if (pins.ce_n || !sync_mode || !pins.we_n) begin
			r_nxt.st = FBRW_IDLE;
			r_nxt.wait_act = 1'b0;
			if (!sync_mode) begin
				r_nxt.addr = addr_pin;
				r_nxt.dq = nonarray_sel ? nonarray_data : array_rdata;
			end
		end else if (valid_edge) begin
			unique case (r.st)
				FBRW_IDLE, FBRW_DONE: begin
					if (!pins.address_valid_n) begin
						r_nxt.st = FBRW_LAT;
						r_nxt.start = addr_pin;
						r_nxt.addr = addr_pin;
						r_nxt.cnt = lat_code;
						r_nxt.words = '0;
						r_nxt.row_done = 1'b0;
						r_nxt.nonarray = nonarray_sel;
					end
				end
				FBRW_LAT, FBRW_RWAIT: begin
					if (r.cnt <= 3'h1) begin
						r_nxt.st = FBRW_DATA;
						r_nxt.dq = r.nonarray ? nonarray_data : array_rdata;
						r_nxt.hold = hold2;
						r_nxt.words = r.words + 5'h01;
						if (!r.nonarray) begin
							r_nxt.addr = step_addr;
						end
					end else begin
						r_nxt.cnt = r.cnt - 3'h1;
					end
				end
				FBRW_DATA: begin
					if (r.hold) begin
						r_nxt.hold = 1'b0;
					end else if (r.nonarray) begin
						// same word again, no row handling
						r_nxt.dq = nonarray_data;
						r_nxt.hold = hold2;
					end else if (fixed_len && r.words == burst_words(blen)) begin
						r_nxt.st = FBRW_DONE;
					end else if (!fixed_len && r.addr == r.start && r.words != '0 && at_top) begin
						r_nxt.st = FBRW_DONE;
					end else if (nowrap && !hold2 && !r.row_done && ws != '0
							&& r.addr[`FBRW_ROW_W-1:0] == '0) begin
						r_nxt.st = FBRW_RWAIT;
						r_nxt.row_done = 1'b1;
						r_nxt.cnt = ws;
					end else begin
						r_nxt.dq = array_rdata;
						r_nxt.hold = hold2;
						r_nxt.words = r.words + 5'h01;
						r_nxt.addr = step_addr;
						if (r.addr[`FBRW_ROW_W-1:0] == '0) begin
							r_nxt.row_done = 1'b1;
						end
						if (at_top && !fixed_len) begin
							r_nxt.start = r.addr;
						end
					end
				end
				default: r_nxt.st = FBRW_IDLE;
			endcase

			// wait shows data not yet valid, dropping lead edges early
			if (r_nxt.st == FBRW_LAT || r_nxt.st == FBRW_RWAIT) begin
				r_nxt.wait_act = (r_nxt.cnt > lead);
			end else begin
				r_nxt.wait_act = 1'b0;
			end
		end

		r_nxt.wait_oe = bus_on;
		r_nxt.wait_lvl = r.cfg[`FBRW_WP] ? r_nxt.wait_act : ~r_nxt.wait_act;
		r_nxt.dq_oe = bus_on & pins.we_n;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			r <= '0;
			r.st <= FBRW_IDLE;
			r.cfg <= `FBRW_CFG_RESET;
		end else begin
			r <= r_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign array_addr = r.addr;
	assign dq_o = r.dq;
	assign dq_oe = r.dq_oe;
	assign wait_o = r.wait_lvl;
	assign wait_oe = r.wait_oe;
	assign reg_rdata = r.rdata;
endmodule

// >>> design/fbrw_map.svh
// constants for the flash burst read and wait control block
// ****************************************************************
`ifndef FBRW_MAP_SVH
`define FBRW_MAP_SVH
`define FBRW_ADDR_W 24
`define FBRW_OFF_CFG 4'h0
`define FBRW_OFF_STAT 4'h4
`define FBRW_CFG_RESET 16'hBFCF
`define FBRW_CFG_WMASK 16'hBFCF
`define FBRW_READ_MODE 15
`define FBRW_LAT_HI 13
`define FBRW_LAT_LO 11
`define FBRW_WP 10
`define FBRW_HOLD2 9
`define FBRW_WAIT_EARLY 8
`define FBRW_CE 6
`define FBRW_WRAP_OFF 3
`define FBRW_BLEN_HI 2
`define FBRW_BLEN_LO 0
`define FBRW_BLEN_4 3'h1
`define FBRW_BLEN_8 3'h2
`define FBRW_BLEN_16 3'h3
`define FBRW_BLEN_CONT 3'h7
`define FBRW_LEN_4 5'h04
`define FBRW_LEN_8 5'h08
`define FBRW_LEN_16 5'h10
`define FBRW_MASK_4 4'h3
`define FBRW_MASK_8 4'h7
`define FBRW_MASK_16 4'hF
`define FBRW_ROW_W 4
`define FBRW_GRP_W 2
`define FBRW_GRP_FULL 3'h4
`endif

// >>> design/fbrw_pkg.sv
// types for the flash burst read and wait control block
package fbrw_pkg;
	typedef enum logic [2:0] {
		FBRW_IDLE,
		FBRW_LAT,
		FBRW_DATA,
		FBRW_RWAIT,
		FBRW_DONE
	} fbrw_state_t;

	typedef struct packed {
		logic clk_pin;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic address_valid_n;
	} fbrw_pins_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} fbrw_reg_req_t;
endpackage

// >>> design/fbrw_edge.sv
// valid clock edge detector on the flash clock pin
`timescale 1ns/1ps
`include "fbrw_map.svh"
module fbrw_edge
	import fbrw_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_pin,
	input wire logic rise_sel,
	output logic valid_edge
);
	typedef struct packed {
		logic prev;
		logic edge_seen;
	} fbrw_edge_regs_t;

	fbrw_edge_regs_t r;
	fbrw_edge_regs_t r_nxt;

	always_comb begin
		r_nxt = r;
		r_nxt.prev = clk_pin;
		// rising or falling edge of the pin as selected
		r_nxt.edge_seen = rise_sel ? (clk_pin & ~r.prev) : (~clk_pin & r.prev);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign valid_edge = r.edge_seen;
endmodule

// >>> design/fbrw_addr_step.sv
// next linear burst address with optional wrap and top stop
`timescale 1ns/1ps
`include "fbrw_map.svh"
module fbrw_addr_step
	import fbrw_pkg::*;
(
	input wire logic [`FBRW_ADDR_W-1:0] cur,
	input wire logic wrap_en,
	input wire logic [2:0] len_code,
	output logic [`FBRW_ADDR_W-1:0] nxt,
	output logic at_top
);
	logic [`FBRW_ADDR_W-1:0] inc;
	logic [`FBRW_ADDR_W-1:0] m;

	always_comb begin
		inc = cur + `FBRW_ADDR_W'(1);
		m = '0;
		unique case (len_code)
			`FBRW_BLEN_4: m[`FBRW_ROW_W-1:0] = `FBRW_MASK_4;
			`FBRW_BLEN_8: m[`FBRW_ROW_W-1:0] = `FBRW_MASK_8;
			`FBRW_BLEN_16: m[`FBRW_ROW_W-1:0] = `FBRW_MASK_16;
			default: m = '0;
		endcase
		at_top = &cur;
		if (wrap_en) begin
			nxt = (cur & ~m) | (inc & m);
		end else if (at_top) begin
			nxt = cur;
		end else begin
			nxt = inc;
		end
	end
endmodule

// >>> tb/fbrw_assertions.sv
// concurrent checks on the burst read and wait control ports
`timescale 1ns/1ps
`include "fbrw_map.svh"
module fbrw_assertions
	import fbrw_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire fbrw_pins_t pins,
	input wire logic [`FBRW_ADDR_W-1:0] addr_pin,
	input wire logic [15:0] array_rdata,
	input wire logic [`FBRW_ADDR_W-1:0] array_addr,
	input wire logic [15:0] dq_o,
	input wire logic dq_oe,
	input wire logic wait_o,
	input wire logic wait_oe,
	input wire fbrw_reg_req_t reg_req
);
	// ****
	// config shadow, quiet time and cycles since a valid edge
	// ****
	logic [15:0] cfg_r;
	logic p_r;
	logic [2:0] calm_r;
	logic [2:0] since_r;
	always_ff @(posedge clk) begin
		p_r <= pins.clk_pin;
		if (!resetn)
			cfg_r <= `FBRW_CFG_RESET;
		else if (reg_req.wr && reg_req.addr == `FBRW_OFF_CFG)
			cfg_r <= reg_req.wdata & `FBRW_CFG_WMASK;
		if (!resetn || pins.ce_n || !pins.we_n || reg_req.wr)
			calm_r <= 3'h0;
		else if (calm_r != 3'h7)
			calm_r <= calm_r + 3'h1;
		if (!resetn)
			since_r <= 3'h7;
		else if (p_r != pins.clk_pin && pins.clk_pin == cfg_r[`FBRW_CE])
			since_r <= 3'h0;
		else if (since_r != 3'h7)
			since_r <= since_r + 3'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_float;
		(pins.ce_n || pins.oe_n) [*3] |-> !wait_oe && !dq_oe;
	endproperty
	a_float: assert property (p_float) else $error("pins driven while deselected");
	property p_wr_float;
		(!pins.we_n) [*3] |-> !dq_oe;
	endproperty
	a_wr_float: assert property (p_wr_float) else $error("data driven in write");
	property p_async_wait;
		cfg_r[`FBRW_READ_MODE] && calm_r > 3'h2 && wait_oe |-> wait_o == !cfg_r[`FBRW_WP];
	endproperty
	a_async_wait: assert property (p_async_wait) else $error("async wait level");
	property p_async_addr;
		cfg_r[`FBRW_READ_MODE] && calm_r > 3'h2 |-> array_addr == $past(addr_pin);
	endproperty
	a_async_addr: assert property (p_async_addr) else $error("async address");
	property p_async_dq;
		cfg_r[`FBRW_READ_MODE] && calm_r > 3'h2 |-> dq_o == $past(array_rdata);
	endproperty
	a_async_dq: assert property (p_async_dq) else $error("async data");
	property p_wait_edge;
		!cfg_r[`FBRW_READ_MODE] && calm_r > 3'h4 && $changed(wait_o) |-> since_r <= 3'h4;
	endproperty
	a_wait_edge: assert property (p_wait_edge) else $error("wait moved off edge");
	property p_dq_edge;
		!cfg_r[`FBRW_READ_MODE] && calm_r > 3'h4 && $changed(dq_o) |-> since_r <= 3'h4;
	endproperty
	a_dq_edge: assert property (p_dq_edge) else $error("data moved off edge");
	property p_step;
		!cfg_r[`FBRW_READ_MODE] && cfg_r[`FBRW_WRAP_OFF] && calm_r > 3'h4
			&& $changed(array_addr)
			&& pins.address_valid_n && $past(pins.address_valid_n, 4)
			|-> array_addr == $past(array_addr) + 1;
	endproperty
	a_step: assert property (p_step) else $error("burst address step");
	c_sync: cover property (!cfg_r[`FBRW_READ_MODE] && dq_oe && !wait_o);
	c_wait: cover property (!cfg_r[`FBRW_READ_MODE] && $rose(wait_o));
	c_async: cover property (cfg_r[`FBRW_READ_MODE] && calm_r > 3'h2);
endmodule

// >>> tb/fbrw_host_model.sv
// host side model: flash clock, strobes and a word array
`timescale 1ns/1ps
`include "fbrw_map.svh"
module fbrw_host_model
	import fbrw_pkg::*;
(
	input wire logic clk,
	input wire logic [`FBRW_ADDR_W-1:0] array_addr,
	input wire logic [15:0] dq_o,
	input wire logic wait_o,
	output fbrw_pins_t pins,
	output logic [`FBRW_ADDR_W-1:0] addr_pin,
	output logic [15:0] array_rdata
);
	logic [15:0] dv[32];
	logic wv[32];
	assign array_rdata = array_addr[15:0] ^ 16'h3C00;
	initial begin
		pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		addr_pin = '0;
	end
	// flash clock stands at its idle level outside a burst
	task burst(input logic [`FBRW_ADDR_W-1:0] a, input logic act, input int n);
		pins <= '{!act, 1'b0, 1'b0, 1'b1, 1'b0};
		addr_pin <= a;
		repeat (6) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			pins.clk_pin <= act;
			repeat (4) @(posedge clk);
			dv[i] = dq_o;
			wv[i] = wait_o;
			pins.clk_pin <= !act;
			pins.address_valid_n <= 1'b1;
			repeat (4) @(posedge clk);
		end
		pins.ce_n <= 1'b1;
		pins.oe_n <= 1'b1;
	endtask
	task wcyc();
		pins <= '{pins.clk_pin, 1'b0, 1'b0, 1'b0, 1'b1};
		repeat (4) @(posedge clk);
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the flash burst read and wait control
`timescale 1ns/1ps
`include "fbrw_map.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
$display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench
	import fbrw_pkg::*;
;
	logic clk;
	logic resetn;
	logic na_sel;
	logic [15:0] na_data;
	logic [15:0] rdata;
	logic [15:0] dq;
	logic [15:0] ardata;
	logic [23:0] aaddr;
	logic [23:0] addr;
	logic [23:0] s;
	logic [23:0] e;
	logic [2:0] b;
	logic [4:0] cnt;
	logic dq_oe;
	logic wt;
	logic wt_oe;
	fbrw_pins_t pins;
	fbrw_reg_req_t rq;
	int n;
	int fail_count;
	int checks_done;
	int cyc;
	logic [23:0] st[3] = '{24'h000001, 24'h000006, 24'h00000C};
	fbrw_ctrl i_dut (.clk(clk), .resetn(resetn), .pins(pins), .addr_pin(addr),
		.nonarray_sel(na_sel), .nonarray_data(na_data), .array_rdata(ardata),
		.array_addr(aaddr), .dq_o(dq), .dq_oe(dq_oe), .wait_o(wt), .wait_oe(wt_oe),
		.reg_req(rq), .reg_rdata(rdata));
	fbrw_host_model i_host (.clk(clk), .array_addr(aaddr), .dq_o(dq), .wait_o(wt),
		.pins(pins), .addr_pin(addr), .array_rdata(ardata));
	function automatic logic [15:0] w(input logic [23:0] a);
		return a[15:0] ^ 16'h3C00;
	endfunction
	function automatic logic [15:0] cf(input logic [2:0] lat, input logic wp, input logic hold,
		input logic early, input logic ce, input logic nowrap, input logic [2:0] blen);
		return {2'b00, lat, wp, hold, early, 1'b1, ce, 2'b00, nowrap, blen};
	endfunction
	task wr(input logic [3:0] a, input logic [15:0] d);
		rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		rq.wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] x);
		rq <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		rq.rd <= 1'b0;
		@(posedge clk);
		`CHK("reg", x, rdata)
	endtask
	task go(input logic [15:0] c, input logic [23:0] a, input logic act, input int k);
		wr(`FBRW_OFF_CFG, c);
		i_host.burst(a, act, k);
		repeat (4) @(posedge clk);
		`CHK("float", 2'b00, {wt_oe, dq_oe})
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// whole run needs about 1200 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		resetn = 1'b0;
		rq = '0;
		na_sel = 1'b0;
		na_data = 16'hA55A;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rd(`FBRW_OFF_STAT, 16'h0000);
		rd(`FBRW_OFF_CFG, `FBRW_CFG_RESET);
		rd(4'h8, 16'h0000);
		i_host.wcyc();
		`CHK("write", 2'b00, {dq_oe, wt})
		go(`FBRW_CFG_RESET, 24'h000123, 1'b1, 2);
		`CHK("async dq", w(24'h000123), i_host.dv[1])
		`CHK("async wait", 1'b0, i_host.wv[1])
		for (int j = 0; j < 6; j++) begin
			b = 3'(j % 3 + 1);
			n = 2 << b;
			s = st[j % 3];
			go(cf(3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'(j / 3), b), s, 1'b1, n + 4);
			`CHK("lead", 1'b1, i_host.wv[2])
			`CHK("first", 1'b0, i_host.wv[3])
			for (int k = 0; k < n; k++) begin
				e = (j < 3) ? 24'((s & ~(n - 1)) | ((s + k) & (n - 1))) : 24'(s + k);
				`CHK("word", w(e), i_host.dv[k + 3])
				`CHK("no wait", 1'b0, i_host.wv[k + 3])
			end
			`CHK("end", w(e), i_host.dv[n + 3])
		end
		go(cf(3'h4, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h1), 24'h000000, 1'b1, 12);
		`CHK("asserted low", 1'b0, i_host.wv[1])
		`CHK("early", 1'b1, i_host.wv[2])
		for (int k = 0; k < 8; k++)
			`CHK("hold", w(24'(k / 2)), i_host.dv[k + 4])
		go(cf(3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h7), 24'h00000F, 1'b1, 26);
		cnt = 5'h00;
		for (int k = 3; k < 26; k++)
			cnt = cnt + 5'(i_host.wv[k]);
		`CHK("row waits", 5'(3 - 1), cnt)
		`CHK("cross", w(24'h000010), i_host.dv[6])
		`CHK("once", w(24'h000020), i_host.dv[22])
		na_sel <= 1'b1;
		go(cf(3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1), 24'h000005, 1'b1, 7);
		for (int k = 3; k < 7; k++)
			`CHK("nonarray", na_data, i_host.dv[k])
		`CHK("na wait", 1'b1, i_host.wv[2])
		na_sel <= 1'b0;
		go(cf(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1), 24'h000002, 1'b0, 8);
		`CHK("fall", w(24'h000002), i_host.dv[3])
		`CHK("fall wrap", w(24'h000001), i_host.dv[6])
		close_out();
	end
endmodule
bind fbrw_ctrl fbrw_assertions i_chk (.clk(clk), .resetn(resetn), .pins(pins),
	.addr_pin(addr_pin), .array_rdata(array_rdata), .array_addr(array_addr), .dq_o(dq_o),
	.dq_oe(dq_oe), .wait_o(wait_o), .wait_oe(wait_oe), .reg_req(reg_req));
